// >>> hdl/twi_master.v
// Two-wire bus master transmitter controller with Avalon-MM register slave
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "twi_master_map.vh"
module twi_master #(
  parameter integer PERIOD_W = 8
) (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_ce,
  input  wire [3:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output wire        o_waitrequest,
  input  wire        i_scl,
  output wire        o_scl,
  output wire        o_scl_oen,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oen
);
  // States, one-hot
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_START = 7'h02;
  localparam [6:0] ST_LOW   = 7'h04;
  localparam [6:0] ST_HIGH  = 7'h08;
  localparam [6:0] ST_HOLD  = 7'h10;
  localparam [6:0] ST_STOP  = 7'h20;
  localparam [6:0] ST_RSTRT = 7'h40;

  // Engine and register state; all of it freezes while the
  // clock enable is low, so a paused bus keeps its lines as they
  // were and resumes without losing a bit
  reg [6:0] state_q;
  reg       enable_q, start_q, stop_q, ack_enable_q, irq_pending_flag_q;
  reg [7:0] shift_data_reg_q;
  reg [7:0] bus_state_reg_q;
  reg [PERIOD_W-1:0] clk_low_period_reg_q, clk_high_period_reg_q;
  reg [PERIOD_W-1:0] sda_hold_delay_reg_q;
  reg [6:0] own_address_reg_q;
  reg [PERIOD_W-1:0] cnt_q;
  reg [3:0] bit_q;
  reg       addr_phase_q, scl_drive_low_q, sda_drive_low_q;
  reg       arb_lost_flag_q, busy_q, ack_q, rx_match_q, sda_set_q;
  reg [7:0] rx_shift_q;
  reg [1:0] scl_sync_q, sda_sync_q;
  reg       scl_prev_q, sda_prev_q, rd_ack_q;

  // The lines come straight from pins and may move at any time;
  // the extra delay of two samples is small against a bit period
  // Synchronised bus lines; first stage read only by second
  wire scl_in = scl_sync_q[1];
  wire sda_in = sda_sync_q[1];
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (i_ce) begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
    end
  end

  // Both edges are judged on synchronised samples; a glitch caught by
  // a single sample is not filtered and reads as a start or a stop
  // Bus condition detection
  wire start_seen = scl_in && scl_prev_q && sda_prev_q && !sda_in;
  wire stop_seen  = scl_in && scl_prev_q && !sda_prev_q && sda_in;
  wire scl_fall   = scl_prev_q && !scl_in;

  // Open-drain outputs: enable low means pull low
  assign o_scl     = 1'b0;
  assign o_sda     = 1'b0;
  assign o_scl_oen = ~(scl_drive_low_q | irq_pending_flag_q);
  assign o_sda_oen = ~sda_drive_low_q;

  // Read answers after one wait cycle; writes complete at once
  // The extra cycle lets read data come from a flip-flop
  assign o_waitrequest = i_read && !rd_ack_q;

  wire       wr       = i_ce && i_write;
  wire [7:0] wdat     = i_writedata[7:0];
  wire       stat_wr  = wr && (i_address == `BUS_STATE_REG_ADDR);
  wire       mode_wr  = wr && (i_address == `MODE_CONTROL_REG_ADDR);
  // Block logic runs only when enabled; clock gate model
  wire       run      = i_ce && enable_q;
  wire       tx_bit   = shift_data_reg_q[7];

  // Only the acknowledge slot and a bus stop raise events here;
  // sending a start raises nothing, and a loss is raised below
  // Event raising: status code and pending flag
  reg        raise;
  reg  [7:0] raise_code;
  always @* begin
    raise      = 1'b0;
    raise_code = 8'h00;
    if (run && state_q == ST_HIGH && bit_q == 4'd8 &&
        cnt_q == 0 && scl_in) begin
      raise = 1'b1;
      raise_code[`STAT_ACK_RX_BIT] = !sda_in;
      if (addr_phase_q)
        raise_code[`STAT_ADDR_DONE_BIT] = 1'b1;
      else
        raise_code[`STAT_BYTE_DONE_BIT] = 1'b1;
    end
    if (run && state_q == ST_IDLE && stop_seen && busy_q) begin
      raise = 1'b1;
      raise_code[`STAT_STOP_BIT] = 1'b1;
    end
  end

  // Checked for address and data bits alike, never for the
  // acknowledge slot, where the slave owns the data line
  // Arbitration loss: drove high, sampled low in clock high
  wire arb_lose = run && state_q == ST_HIGH && bit_q < 4'd8 &&
                  scl_in && tx_bit && !sda_in;

  // A status write in the same cycle as a new event is lost on
  // purpose: software sees the event and must write again
  // Register writes and status flags; event set wins over clear
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      enable_q              <= 1'b0;
      start_q               <= 1'b0;
      stop_q                <= 1'b0;
      ack_enable_q          <= 1'b0;
      own_address_reg_q     <= 7'h00;
      clk_low_period_reg_q  <= `CLK_LOW_RESET;
      clk_high_period_reg_q <= `CLK_HIGH_RESET;
      sda_hold_delay_reg_q  <= `SDA_HOLD_RESET;
      irq_pending_flag_q    <= 1'b0;
      bus_state_reg_q       <= 8'h00;
      rd_ack_q              <= 1'b0;
    end else if (i_ce) begin
      rd_ack_q <= i_read && !rd_ack_q;
      if (mode_wr) begin
        enable_q     <= wdat[`MODE_ENABLE_BIT];
        start_q      <= wdat[`MODE_START_BIT];
        stop_q       <= wdat[`MODE_STOP_BIT];
        ack_enable_q <= wdat[`MODE_ACK_ENABLE_BIT];
      end else begin
        if (run && state_q == ST_START) start_q <= 1'b0;
        if (run && state_q == ST_STOP)  stop_q  <= 1'b0;
      end
      if (wr && i_address == `CLK_LOW_PERIOD_ADDR)
        clk_low_period_reg_q <= wdat[PERIOD_W-1:0];
      if (wr && i_address == `CLK_HIGH_PERIOD_ADDR)
        clk_high_period_reg_q <= wdat[PERIOD_W-1:0];
      if (wr && i_address == `SDA_HOLD_DELAY_ADDR)
        sda_hold_delay_reg_q <= wdat[PERIOD_W-1:0];
      if (wr && i_address == `OWN_ADDRESS_REG_ADDR)
        own_address_reg_q <= wdat[7:1];
      // Any status write clears; a new event wins
      if (raise) begin
        irq_pending_flag_q <= 1'b1;
        bus_state_reg_q    <= raise_code;
      end else if (arb_lose) begin
        irq_pending_flag_q <= 1'b1;
        bus_state_reg_q    <= 8'h00;
        bus_state_reg_q[`STAT_ARB_LOST_BIT] <= 1'b1;
      end else if (stat_wr) begin
        irq_pending_flag_q <= 1'b0;
        bus_state_reg_q    <= 8'h00;
      end
    end
  end

  // The register shifts in the line level as bits go out, so a
  // read after a transfer shows what the bus really carried
  // Data register: address/direction byte, then data bytes
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      shift_data_reg_q <= 8'h00;
    else if (i_ce) begin
      if (wr && i_address == `SHIFT_DATA_REG_ADDR)
        shift_data_reg_q <= wdat;
      else if (run && state_q == ST_HIGH && bit_q < 4'd8 &&
               cnt_q == 0 && scl_in)
        shift_data_reg_q <= {shift_data_reg_q[6:0], sda_in};
    end
  end

  // Busy follows the bus, not this engine, so a start from
  // another master also blocks our own start
  // Bus busy tracking and slave address capture
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q     <= 1'b0;
      rx_shift_q <= 8'h00;
      rx_match_q <= 1'b0;
    end else if (i_ce) begin
      if (start_seen)
        busy_q <= 1'b1;
      else if (stop_seen)
        busy_q <= 1'b0;
      if (scl_in && !scl_prev_q)
        rx_shift_q <= {rx_shift_q[6:0], sda_in};
      // Addressed-slave eligibility after loss
      rx_match_q <= ack_enable_q && (rx_shift_q[7:1] == own_address_reg_q);
    end
  end

  // Every counted phase uses one down counter; a clock held low by
  // a slave stops the count of a bit's high phase until let go, a fall in clock high restarts the low
  // Bit engine: start, eight bits plus acknowledge, stop
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q         <= ST_IDLE;
      cnt_q           <= {PERIOD_W{1'b0}};
      bit_q           <= 4'd0;
      addr_phase_q    <= 1'b0;
      scl_drive_low_q <= 1'b0;
      sda_drive_low_q <= 1'b0;
      arb_lost_flag_q <= 1'b0;
      ack_q           <= 1'b0;
      sda_set_q       <= 1'b0;
    end else if (run) begin
      case (state_q)
        ST_IDLE: begin
          scl_drive_low_q <= 1'b0;
          sda_drive_low_q <= 1'b0;
          if (start_q && !busy_q && !irq_pending_flag_q) begin
            state_q         <= ST_START;
            cnt_q           <= clk_high_period_reg_q;
            arb_lost_flag_q <= 1'b0;
          end
        end
        ST_START: begin
          // Data falls while clock high: start, no interrupt
          sda_drive_low_q <= 1'b1;
          if (cnt_q != 0)
            cnt_q <= cnt_q - 1'b1;
          else begin
            scl_drive_low_q <= 1'b1;
            state_q         <= ST_LOW;
            cnt_q           <= clk_low_period_reg_q;
            bit_q           <= 4'd0;
            addr_phase_q    <= 1'b1;
            sda_set_q       <= 1'b0;
          end
        end
        ST_LOW: begin
          // Data updated after hold, only while clock low
          if (!sda_set_q && cnt_q <=
              clk_low_period_reg_q - sda_hold_delay_reg_q) begin
            sda_set_q <= 1'b1;
            if (bit_q == 4'd8)
              sda_drive_low_q <= 1'b0;
            else
              sda_drive_low_q <= !tx_bit;
          end
          if (cnt_q != 0)
            cnt_q <= cnt_q - 1'b1;
          else begin
            scl_drive_low_q <= 1'b0;
            state_q         <= ST_HIGH;
            cnt_q           <= clk_high_period_reg_q;
          end
        end
        ST_HIGH: begin
          if (arb_lose) begin
            // Lost: release data, go idle; the pending flag then holds the clock low
            arb_lost_flag_q <= 1'b1;
            sda_drive_low_q <= 1'b0;
            state_q         <= ST_IDLE;
          end else if (!scl_in) begin
            // Wait while released clock is held low
            if (scl_fall) begin
              // Another master pulled low: restart own low
              scl_drive_low_q <= 1'b1;
              state_q         <= ST_LOW;
              cnt_q           <= clk_low_period_reg_q;
              sda_set_q       <= 1'b0;
            end
          end else if (cnt_q != 0)
            cnt_q <= cnt_q - 1'b1;
          else begin
            scl_drive_low_q <= 1'b1;
            sda_set_q       <= 1'b0;
            cnt_q           <= clk_low_period_reg_q;
            if (bit_q == 4'd8) begin
              ack_q   <= !sda_in;
              state_q <= ST_HOLD;
            end else begin
              bit_q   <= bit_q + 1'b1;
              state_q <= ST_LOW;
            end
          end
        end
        ST_HOLD: begin
          // Clock held by pending flag; then software choice
          // Data line stays released here until a stop is chosen
          scl_drive_low_q <= 1'b1;
          if (!irq_pending_flag_q) begin
            addr_phase_q <= 1'b0;
            bit_q        <= 4'd0;
            cnt_q        <= clk_low_period_reg_q;
            if (stop_q) begin
              state_q         <= ST_STOP;
              sda_drive_low_q <= 1'b1;
            end else if (start_q) begin
              state_q         <= ST_RSTRT;
              sda_drive_low_q <= 1'b0;
            end else begin
              state_q <= ST_LOW;
            end
          end
        end
        ST_STOP: begin
          // Release clock, then raise data: stop condition
          if (cnt_q != 0)
            cnt_q <= cnt_q - 1'b1;
          else if (scl_drive_low_q) begin
            scl_drive_low_q <= 1'b0;
            cnt_q           <= clk_high_period_reg_q;
          end else if (scl_in) begin
            sda_drive_low_q <= 1'b0;
            state_q         <= ST_IDLE;
          end
        end
        ST_RSTRT: begin
          // Data high, clock released, then a fresh start
          if (cnt_q != 0)
            cnt_q <= cnt_q - 1'b1;
          else if (scl_drive_low_q) begin
            scl_drive_low_q <= 1'b0;
            cnt_q           <= clk_high_period_reg_q;
          end else if (scl_in) begin
            state_q <= ST_START;
            cnt_q   <= clk_high_period_reg_q;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Loaded only on a read, so the value stands until the next
  // read even if the registers behind it move
  // Register read mux; unmapped reads zero
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      o_readdata <= 32'h0000_0000;
    else if (i_ce && i_read) begin
      o_readdata <= 32'h0000_0000;
      case (i_address)
        `MODE_CONTROL_REG_ADDR:
          o_readdata[7:0] <= {irq_pending_flag_q, 3'b000, ack_enable_q,
                              stop_q, start_q, enable_q};
        `SHIFT_DATA_REG_ADDR:  o_readdata[7:0] <= shift_data_reg_q;
        `BUS_STATE_REG_ADDR:
          o_readdata[7:0] <= {state_q != ST_IDLE, busy_q,
                              arb_lost_flag_q && rx_match_q,
                              bus_state_reg_q[4:0] |
                              {arb_lost_flag_q, 4'b0000}};
        `CLK_LOW_PERIOD_ADDR:  o_readdata[PERIOD_W-1:0] <= clk_low_period_reg_q;
        `CLK_HIGH_PERIOD_ADDR: o_readdata[PERIOD_W-1:0] <= clk_high_period_reg_q;
        `SDA_HOLD_DELAY_ADDR:  o_readdata[PERIOD_W-1:0] <= sda_hold_delay_reg_q;
        `OWN_ADDRESS_REG_ADDR: o_readdata[7:0] <= {own_address_reg_q, 1'b0};
        default:               o_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // twi_master
`default_nettype wire

// >>> include/twi_master_map.vh
// Register map, field positions and timing constants for the two-wire master
`ifndef TWI_MASTER_MAP_VH
`define TWI_MASTER_MAP_VH
// Register byte addresses
`define MODE_CONTROL_REG_ADDR  4'h0
`define SHIFT_DATA_REG_ADDR    4'h1
`define BUS_STATE_REG_ADDR     4'h2
`define CLK_LOW_PERIOD_ADDR    4'h3
`define CLK_HIGH_PERIOD_ADDR   4'h4
`define SDA_HOLD_DELAY_ADDR    4'h5
`define OWN_ADDRESS_REG_ADDR   4'h6
// Mode control fields
`define MODE_ENABLE_BIT        0
`define MODE_START_BIT         1
`define MODE_STOP_BIT          2
`define MODE_ACK_ENABLE_BIT    3
`define MODE_IRQ_FLAG_BIT      7
// Bus state fields
`define STAT_ACK_RX_BIT        0
`define STAT_ADDR_DONE_BIT     1
`define STAT_BYTE_DONE_BIT     2
`define STAT_STOP_BIT          3
`define STAT_ARB_LOST_BIT      4
`define STAT_SLAVE_SEL_BIT     5
`define STAT_BUSY_BIT          6
`define STAT_MASTER_BIT        7
// Reset values
`define CLK_LOW_RESET          8'h0020
`define CLK_HIGH_RESET         8'h0020
`define SDA_HOLD_RESET         8'h0010
`endif

// >>> bench/twi_master_assertions.sv
// Port-level assertions for the two-wire master controller
`timescale 1ns/1ps
`default_nettype none
module twi_master_assertions (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic        o_waitrequest,
  input wire logic [31:0] o_readdata,
  input wire logic        i_scl,
  input wire logic        o_scl,
  input wire logic        o_scl_oen,
  input wire logic        i_sda,
  input wire logic        o_sda,
  input wire logic        o_sda_oen
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Pins may only pull low or float
  property p_open_drain; o_scl == 1'b0 && o_sda == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("bus pin driven high");
  // Register writes never stall, reads stall exactly one cycle
  property p_wr_fast; i_write |-> !o_waitrequest; endproperty
  a_wr_fast: assert property (p_wr_fast)
    else $error("write stalled");
  property p_rd_wait;
    $rose(i_read) |-> o_waitrequest ##1 !o_waitrequest;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read answer late");
  property p_rd_hold; !i_read |=> $stable(o_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  // Own clock phases last more than a cycle
  property p_high_min; $rose(o_scl_oen) |=> o_scl_oen; endproperty
  a_high_min: assert property (p_high_min)
    else $error("clock high phase too short");
  property p_low_min; $fell(o_scl_oen) |=> !o_scl_oen [*2]; endproperty
  a_low_min: assert property (p_low_min)
    else $error("clock low phase too short");
  // Released but held low long after the edge: a stretching slave
  property p_stretch; (o_scl_oen && !i_scl) [*4] |=> o_scl_oen; endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock pulled during stretch");
  // A start only on a free, high data line
  property p_start_ok;
    $fell(o_sda_oen) && o_scl_oen && $past(o_scl_oen) && i_scl
      |-> $past(i_sda);
  endproperty
  a_start_ok: assert property (p_start_ok)
    else $error("start on a low data line");
  c_start: cover property ($fell(o_sda_oen) && i_scl);
  c_stretch: cover property ((o_scl_oen && !i_scl) [*4]);
  c_read: cover property ($rose(i_read));
endmodule // twi_master_assertions
bind twi_master twi_master_assertions twi_master_assertions_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_read(i_read), .i_write(i_write),
  .o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
  .i_scl(i_scl), .o_scl(o_scl), .o_scl_oen(o_scl_oen),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oen(o_sda_oen));
`default_nettype wire

// >>> bench/twi_slave_model.sv
// Behavioural bus slave: receives bytes, acknowledges, stretches the clock
`timescale 1ns/1ps
`default_nettype none
module twi_slave_model (
  input  wire logic       i_clk,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_ack_en,
  input  wire logic       i_stretch,
  output logic            o_scl_oen,
  output logic            o_sda_oen,
  output logic [7:0]      o_byte,
  output logic [3:0]      o_nbytes,
  output logic [3:0]      o_nstops
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [3:0] bit_q = 4'h0;
  logic [7:0] sh_q = 8'h00;
  logic [4:0] hold_q = 5'h00;
  initial begin
    o_scl_oen = 1'b1;
    o_sda_oen = 1'b1;
    o_byte = 8'h00;
    o_nbytes = 4'h0;
    o_nstops = 4'h0;
  end
  // Edges seen on the first sample, raw line against the last sample
  always @(posedge i_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (hold_q != 5'h00) begin
      hold_q <= hold_q - 5'h01;
      o_scl_oen <= (hold_q == 5'h01);
    end
    if (scl_q && i_scl && sda_q && !i_sda) begin
      bit_q <= 4'h0;
    end else if (scl_q && i_scl && !sda_q && i_sda) begin
      o_nstops <= o_nstops + 4'h1;
    end else if (!scl_q && i_scl && bit_q < 4'h8) begin
      sh_q <= {sh_q[6:0], i_sda};
      bit_q <= bit_q + 4'h1;
    end else if (!scl_q && i_scl && bit_q == 4'h9) begin
      bit_q <= 4'hA;
    end else if (scl_q && !i_scl && bit_q == 4'h8) begin
      o_sda_oen <= !i_ack_en; // Low through the ninth high
      o_byte <= sh_q;
      o_nbytes <= o_nbytes + 4'h1;
      bit_q <= 4'h9;
    end else if (scl_q && !i_scl && bit_q == 4'hA) begin
      o_sda_oen <= 1'b1; // Let go so the master may stop
      bit_q <= 4'h0;
      if (i_stretch) begin
        o_scl_oen <= 1'b0; // Busy between bytes
        hold_q <= 5'h18;
      end
    end
  end
endmodule // twi_slave_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench: registers, transfers, stretch, stop, lost arbitration
`timescale 1ns/1ps
`default_nettype none
`include "twi_master_map.vh"
module tb;
  localparam logic [7:0] M_EN = 8'h01 << `MODE_ENABLE_BIT;
  localparam logic [7:0] M_GO = M_EN | (8'h01 << `MODE_START_BIT)
                              | (8'h01 << `MODE_ACK_ENABLE_BIT);
  localparam logic [7:0] M_STOP = M_EN | (8'h01 << `MODE_STOP_BIT);
  logic        i_clk = 1'b0;
  logic        i_rstn, i_ce, i_read, i_write, ack_en, stretch, tb_sda_low;
  logic [3:0]  i_address;
  logic [31:0] i_writedata, rd_q;
  wire  [31:0] o_readdata;
  wire         o_waitrequest, o_scl, o_scl_oen, o_sda, o_sda_oen;
  wire         s_scl_oen, s_sda_oen, scl_line, sda_line;
  wire  [7:0]  s_byte;
  wire  [3:0]  s_nbytes, s_nstops;
  logic        ack_a;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Wired-AND bus with pull-ups
  assign scl_line = o_scl_oen & s_scl_oen;
  assign sda_line = o_sda_oen & s_sda_oen & !tb_sda_low;
  always #50 i_clk = ~i_clk;
  twi_master twi_master_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_scl(scl_line), .o_scl(o_scl),
    .o_scl_oen(o_scl_oen), .i_sda(sda_line), .o_sda(o_sda),
    .o_sda_oen(o_sda_oen));
  twi_slave_model twi_slave_model_i (.i_clk(i_clk), .i_scl(scl_line),
    .i_sda(sda_line), .i_ack_en(ack_en), .i_stretch(stretch),
    .o_scl_oen(s_scl_oen), .o_sda_oen(s_sda_oen), .o_byte(s_byte),
    .o_nbytes(s_nbytes), .o_nstops(s_nstops));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_write <= 1'b1;
    i_address <= a;
    i_writedata <= {24'h00_0000, d};
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_read <= 1'b1;
    i_address <= a;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd_q = o_readdata;
    i_read <= 1'b0;
  endtask
  // Poll one flag; gives up after a bounded number of reads
  task automatic wait_bit(input logic [3:0] a, input int b);
    for (int k = 0; k < 400; k++) begin
      rd(a);
      if (rd_q[b] === 1'b1) break;
    end
    check({7'h00, rd_q[b]}, 8'h01);
  endtask
  task automatic scl_held;
    int hi = 0;
    repeat (30) @(posedge i_clk) if (scl_line !== 1'b0) hi++;
    check(hi[7:0], 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #4_000_000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    {i_rstn, i_read, i_write, stretch, tb_sda_low} = 5'h00;
    {i_ce, ack_en} = 2'b11;
    i_address = 4'h0;
    i_writedata = 32'h0000_0000;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(`CLK_LOW_PERIOD_ADDR);
    check(rd_q[7:0], `CLK_LOW_RESET);
    rd(`CLK_HIGH_PERIOD_ADDR);
    check(rd_q[7:0], `CLK_HIGH_RESET);
    rd(`SDA_HOLD_DELAY_ADDR);
    check(rd_q[7:0], `SDA_HOLD_RESET);
    rd(4'hF);
    check(rd_q[7:0], 8'h00);
    $display("test reset values done");
    // Start with the block disabled: the lines must stay idle
    wr(`MODE_CONTROL_REG_ADDR, 8'h01 << `MODE_START_BIT);
    repeat (100) @(posedge i_clk);
    check({6'h00, scl_line, sda_line}, 8'h03);
    // Short bit time: 5 + 5 counted cycles, data moves mid-low
    wr(`CLK_LOW_PERIOD_ADDR, 8'h04);
    wr(`CLK_HIGH_PERIOD_ADDR, 8'h04);
    wr(`SDA_HOLD_DELAY_ADDR, 8'h02);
    rd(`CLK_HIGH_PERIOD_ADDR);
    check(rd_q[7:0], 8'h04);
    wr(`SHIFT_DATA_REG_ADDR, 8'hA4);
    wr(`MODE_CONTROL_REG_ADDR, M_GO);
    wait_bit(`MODE_CONTROL_REG_ADDR, `MODE_IRQ_FLAG_BIT);
    check(s_byte, 8'hA4);
    rd(`BUS_STATE_REG_ADDR);
    check({rd_q[`STAT_ADDR_DONE_BIT], rd_q[`STAT_BUSY_BIT]}, 8'h03);
    scl_held;
    $display("test address phase done");
    // Two data bytes, the second behind a stretching slave
    for (int k = 0; k < 2; k++) begin
      stretch <= k[0];
      wr(`SHIFT_DATA_REG_ADDR, k[0] ? 8'h81 : 8'h3C);
      wr(`BUS_STATE_REG_ADDR, 8'h00);
      wait_bit(`BUS_STATE_REG_ADDR, `STAT_BYTE_DONE_BIT);
      check(s_byte, k[0] ? 8'h81 : 8'h3C);
      ack_a = rd_q[`STAT_ACK_RX_BIT];
    end
    check({4'h0, s_nbytes}, 8'h03);
    $display("test data bytes done");
    // Unacknowledged byte, then stop
    stretch <= 1'b0;
    ack_en <= 1'b0;
    wr(`SHIFT_DATA_REG_ADDR, 8'h55);
    wr(`BUS_STATE_REG_ADDR, 8'h00);
    wait_bit(`BUS_STATE_REG_ADDR, `STAT_BYTE_DONE_BIT);
    check({7'h00, ack_a ^ rd_q[`STAT_ACK_RX_BIT]}, 8'h01);
    wr(`MODE_CONTROL_REG_ADDR, M_STOP);
    wr(`BUS_STATE_REG_ADDR, 8'h00);
    wait_bit(`BUS_STATE_REG_ADDR, `STAT_STOP_BIT);
    check({4'h0, s_nstops}, 8'h01);
    wr(`BUS_STATE_REG_ADDR, 8'h00);
    rd(`BUS_STATE_REG_ADDR);
    check(rd_q[7:0], 8'h00);
    $display("test stop done");
    // Another master keeps data low while we send a one
    ack_en <= 1'b1;
    wr(`SHIFT_DATA_REG_ADDR, 8'hFF);
    wr(`MODE_CONTROL_REG_ADDR, M_GO);
    @(negedge scl_line);
    repeat (2) @(posedge i_clk);
    tb_sda_low <= 1'b1;
    wait_bit(`BUS_STATE_REG_ADDR, `STAT_ARB_LOST_BIT);
    check({7'h00, o_sda_oen}, 8'h01);
    tb_sda_low <= 1'b0;
    $display("test arbitration done");
    print_verdict;
  end
endmodule // tb
`default_nettype wire
